// *** bench/cst_mem.sv ***
// Zero-wait program and data memory on the processor bus.
`timescale 1ns/1ns
module cst_mem (
  input wire logic core_clk,
  input wire cst_pkg::cst_bus_t bus,
  output logic [7:0] bus_rdata
);
  logic [7:0] cells [0:65535];
  logic [7:0] last_q = 8'h00;

  always @(posedge core_clk)
  begin
    if (!bus.rd_nwr)
      cells[bus.addr] <= bus.wdata;
    last_q <= bus_rdata;
  end

  // During writes the read lines are not driven, so they show a changing pattern.
  assign bus_rdata = bus.rd_nwr ? cells[bus.addr] : ~last_q;
endmodule : cst_mem

// *** bench/tb.sv ***
// Self-checking bench for the subtract, trap and transfer sequencer.
`timescale 1ns/1ns
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      bad_count++; \
      $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module tb;
  typedef cst_pkg::cst_bus_t cst_cyc_q_t[$];
  typedef logic [7:0] cst_byte_q_t[$];
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic test_mode = 1'b0;
  logic nmi_taken = 1'b0;
  logic [7:0] bus_rdata;
  cst_pkg::cst_bus_t bus;
  cst_pkg::cst_regs_t regs;
  cst_pkg::cst_flags_t flags;
  logic illegal_op;
  int bad_count = 0;
  int total_checks = 0;

  cst_seq #(.TRAP_VEC(16'hFF80)) dut (.core_clk(core_clk), .rstn(rstn), .test_mode(test_mode),
    .nmi_taken(nmi_taken), .bus_rdata(bus_rdata), .bus(bus), .regs(regs), .flags(flags),
    .illegal_op(illegal_op));
  cst_mem mem_i (.core_clk(core_clk), .bus(bus), .bus_rdata(bus_rdata));

  initial
  begin
    forever #4 core_clk = ~core_clk;
  end

  function automatic cst_pkg::cst_bus_t rd(input logic [15:0] a);
    return '{addr: a, wdata: 8'h00, rd_nwr: 1'b1};
  endfunction : rd

  function automatic cst_pkg::cst_bus_t wr(input logic [15:0] a, input logic [7:0] d);
    return '{addr: a, wdata: d, rd_nwr: 1'b0};
  endfunction : wr

  task automatic ld(input logic [15:0] a, input cst_byte_q_t d);
    foreach (d[k])
      mem_i.cells[a + 16'(k)] = d[k];
  endtask : ld

  // Clears memory, loads the program at 0000 and releases reset on a rising edge.
  task automatic reset_dut(input cst_byte_q_t prog);
    @(posedge core_clk);
    rstn <= 1'b0;
    for (int k = 0; k < 65536; k++)
      mem_i.cells[k] = 8'h00;
    ld(16'h0000, prog);
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    @(negedge core_clk);
  endtask : reset_dut

  // Checks each bus cycle of one instruction, then the flags, A and B it leaves.
  task automatic instr(input cst_cyc_q_t e, input logic [7:0] f, input logic [7:0] a, input logic [7:0] b);
    foreach (e[k])
    begin
      `CHK(bus, e[k])
      @(negedge core_clk);
    end
    `CHK(flags, f)
    `CHK(regs.a, a)
    `CHK(regs.b, b)
  endtask : instr

  task automatic test_subtract();
    reset_dut('{8'h83, 8'h12, 8'h34, 8'h93, 8'h80, 8'hB3, 8'h20, 8'h00, 8'hA3, 8'h90, 8'h18, 8'hA3, 8'hA0});
    ld(16'h0080, '{8'hED, 8'hCC});
    ld(16'h2000, '{8'h80, 8'h00});
    ld(16'h0090, '{8'h7F, 8'hFF});
    ld(16'h00A0, '{8'h00, 8'h01});
    instr('{rd(16'h0000), rd(16'h0001), rd(16'h0002), rd(16'hFFFF)}, 8'hD9, 8'hED, 8'hCC);
    instr('{rd(16'h0003), rd(16'h0004), rd(16'h0080), rd(16'h0081), rd(16'hFFFF)}, 8'hD4, 8'h00, 8'h00);
    instr('{rd(16'h0005), rd(16'h0006), rd(16'h0007), rd(16'h2000), rd(16'h2001), rd(16'hFFFF)},
      8'hDB, 8'h80, 8'h00);
    instr('{rd(16'h0008), rd(16'h0009), rd(16'hFFFF), rd(16'h0090), rd(16'h0091), rd(16'hFFFF)},
      8'hD2, 8'h00, 8'h01);
    instr('{rd(16'h000A), rd(16'h000B), rd(16'h000C), rd(16'hFFFF), rd(16'h00A0), rd(16'h00A1), rd(16'hFFFF)},
      8'hD4, 8'h00, 8'h00);
  endtask : test_subtract

  task automatic test_trap();
    reset_dut('{8'h83, 8'h12, 8'h34, 8'h06, 8'h3F});
    ld(16'hFF80, '{8'h03, 8'h00});
    instr('{rd(16'h0000), rd(16'h0001), rd(16'h0002), rd(16'hFFFF)}, 8'hD9, 8'hED, 8'hCC);
    instr('{rd(16'h0003), rd(16'h0004)}, 8'hED, 8'hED, 8'hCC);
    instr('{rd(16'h0004), rd(16'h0005), wr(16'h00FF, 8'h05), wr(16'h00FE, 8'h00), wr(16'h00FD, 8'h00),
      wr(16'h00FC, 8'h00), wr(16'h00FB, 8'h00), wr(16'h00FA, 8'h00), wr(16'h00F9, 8'hED), wr(16'h00F8, 8'hCC),
      wr(16'h00F7, 8'hED), rd(16'h00F7), rd(16'hFF80), rd(16'hFF81)}, 8'hFD, 8'hED, 8'hCC);
    `CHK(bus, rd(16'h0300))
    `CHK(regs.sp, 16'h00F6)
    `CHK(mem_i.cells[16'h00F7], 8'hED)
  endtask : test_trap

  task automatic test_transfer();
    reset_dut('{8'h83, 8'h80, 8'h00, 8'h16, 8'h83, 8'h00, 8'h80, 8'h17, 8'h07});
    instr('{rd(16'h0000), rd(16'h0001), rd(16'h0002), rd(16'hFFFF)}, 8'hDB, 8'h80, 8'h00);
    instr('{rd(16'h0003), rd(16'h0004)}, 8'hD9, 8'h80, 8'h80);
    instr('{rd(16'h0004), rd(16'h0005), rd(16'h0006), rd(16'hFFFF)}, 8'hD8, 8'h80, 8'h00);
    instr('{rd(16'h0007), rd(16'h0008)}, 8'hD4, 8'h00, 8'h00);
    instr('{rd(16'h0008), rd(16'h0009)}, 8'hD4, 8'hD4, 8'h00);
  endtask : test_transfer

  task automatic test_flag_load();
    reset_dut('{8'h83, 8'hE0, 8'h00, 8'h06, 8'h83, 8'hE0, 8'h00, 8'h06, 8'h07, 8'h00});
    instr('{rd(16'h0000), rd(16'h0001), rd(16'h0002), rd(16'hFFFF)}, 8'hD1, 8'h20, 8'h00);
    instr('{rd(16'h0003), rd(16'h0004)}, 8'h20, 8'h20, 8'h00);
    instr('{rd(16'h0004), rd(16'h0005), rd(16'h0006), rd(16'hFFFF)}, 8'h21, 8'h40, 8'h00);
    instr('{rd(16'h0007), rd(16'h0008)}, 8'h00, 8'h40, 8'h00);
    instr('{rd(16'h0008), rd(16'h0009)}, 8'h00, 8'h00, 8'h00);
    instr('{rd(16'h0009)}, 8'h00, 8'h00, 8'h00);
    `CHK(illegal_op, 1'b1)
    `CHK(bus, rd(16'h000A))
    @(posedge core_clk);
    nmi_taken <= 1'b1;
    @(posedge core_clk);
    nmi_taken <= 1'b0;
    @(negedge core_clk);
    `CHK(flags.x, 1'b1)
  endtask : test_flag_load

  task automatic test_compare();
    reset_dut('{8'h83, 8'h80, 8'h00, 8'h4D, 8'h5D, 8'h7D, 8'h30, 8'h00, 8'h6D, 8'h50, 8'h18, 8'h6D, 8'h60});
    ld(16'h3000, '{8'h7F});
    ld(16'h0050, '{8'h80});
    instr('{rd(16'h0000), rd(16'h0001), rd(16'h0002), rd(16'hFFFF)}, 8'hDB, 8'h80, 8'h00);
    instr('{rd(16'h0003), rd(16'h0004)}, 8'hD8, 8'h80, 8'h00);
    instr('{rd(16'h0004), rd(16'h0005)}, 8'hD4, 8'h80, 8'h00);
    instr('{rd(16'h0005), rd(16'h0006), rd(16'h0007), rd(16'h3000), rd(16'hFFFF), rd(16'hFFFF)},
      8'hD0, 8'h80, 8'h00);
    instr('{rd(16'h0008), rd(16'h0009), rd(16'hFFFF), rd(16'h0050), rd(16'hFFFF), rd(16'hFFFF)},
      8'hD8, 8'h80, 8'h00);
    instr('{rd(16'h000A), rd(16'h000B), rd(16'h000C), rd(16'hFFFF), rd(16'h0060), rd(16'hFFFF), rd(16'hFFFF)},
      8'hD4, 8'h80, 8'h00);
    `CHK(mem_i.cells[16'h3000], 8'h7F)
    `CHK(mem_i.cells[16'h0050], 8'h80)
  endtask : test_compare

  task automatic test_count_mode();
    @(posedge core_clk);
    test_mode <= 1'b1;
    reset_dut('{8'h00});
    for (int k = 0; k < 20; k++)
    begin
      `CHK(bus, rd(16'(k)))
      `CHK(illegal_op, 1'b0)
      @(negedge core_clk);
    end
    reset_dut('{8'h00});
    `CHK(bus, rd(16'h0000))
  endtask : test_count_mode

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  initial
  begin
    #(8 * 4000);
    bad_count++;
    $display("mismatch at %0t: run did not complete", $time);
    finish_test();
  end

  initial
  begin
    test_subtract();
    test_trap();
    test_transfer();
    test_flag_load();
    test_compare();
    test_count_mode();
    finish_test();
  end
endmodule : tb

// *** design/cst_flag8.sv ***
// Byte flag terms and the guarded load of flags from a byte.
`timescale 1ns/1ns
module cst_flag8 (
  input wire logic [7:0] val,
  input wire logic [7:0] tap_src,
  input wire cst_pkg::cst_flags_t cur,
  output logic neg,
  output logic zero,
  output cst_pkg::cst_flags_t tap_flags
);

  assign neg = val[7];
  assign zero = (val == 8'h00);

  // The nonmaskable mask may drop but never rise through this path.
  always_comb
  begin
    tap_flags = tap_src;
    tap_flags.x = tap_src[6] & cur.x;
  end

endmodule : cst_flag8

// *** design/cst_pkg.sv ***
// Shared types and constants for the subtract, trap and transfer sequencer.
package cst_pkg;

  // Condition flags, bit 7 down to bit 0.
  typedef struct packed {
    logic s;
    logic x;
    logic h;
    logic i;
    logic n;
    logic z;
    logic v;
    logic c;
  } cst_flags_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [15:0] sp;
    logic [15:0] iy;
    logic [15:0] ix;
    logic [7:0] a;
    logic [7:0] b;
  } cst_regs_t;

  // One processor bus cycle: rd_nwr high reads, low writes.
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic rd_nwr;
  } cst_bus_t;

  typedef enum logic [1:0] {
    ST_FETCH = 2'h0,
    ST_EXEC = 2'h1,
    ST_TEST = 2'h3
  } cst_state_t;

  typedef enum logic [2:0] {
    AM_INH = 3'h0,
    AM_IMM = 3'h1,
    AM_DIR = 3'h2,
    AM_EXT = 3'h3,
    AM_IDX = 3'h4
  } cst_amode_t;

  localparam logic [7:0] OP_PFX_Y = 8'h18;
  localparam logic [7:0] OP_DSUB_IMM = 8'h83;
  localparam logic [7:0] OP_DSUB_DIR = 8'h93;
  localparam logic [7:0] OP_DSUB_EXT = 8'hB3;
  localparam logic [7:0] OP_DSUB_IDX = 8'hA3;
  localparam logic [7:0] OP_TRAP = 8'h3F;
  localparam logic [7:0] OP_A2B = 8'h16;
  localparam logic [7:0] OP_B2A = 8'h17;
  localparam logic [7:0] OP_TAP = 8'h06;
  localparam logic [7:0] OP_RDFLAGS = 8'h07;
  localparam logic [7:0] OP_TEST = 8'h00;
  localparam logic [7:0] OP_CMPZ_A = 8'h4D;
  localparam logic [7:0] OP_CMPZ_B = 8'h5D;
  localparam logic [7:0] OP_CMPZ_EXT = 8'h7D;
  localparam logic [7:0] OP_CMPZ_IDX = 8'h6D;

  localparam logic [15:0] IDLE_ADDR = 16'hFFFF;
  localparam logic [15:0] TRAP_VEC_DFLT = 16'hFFF0;

  // Bus cycle numbers inside an instruction, counted from the opcode fetch.
  localparam logic [3:0] CYC_FIRST = 4'h1;
  localparam logic [3:0] CYC_OPND = 4'h2;
  localparam logic [3:0] CYC_PUSH0 = 4'h3;
  localparam logic [3:0] CYC_PUSH8 = 4'hB;
  localparam logic [3:0] CYC_REREAD = 4'hC;
  localparam logic [3:0] CYC_VEC_HI = 4'hD;
  localparam logic [3:0] CYC_TRAP_LAST = 4'hE;
  localparam logic [3:0] CYC_DIR_DATA = 4'h3;
  localparam logic [3:0] CYC_EXT_DATA = 4'h4;

  localparam cst_regs_t REGS_RST = '{16'h0000, 16'h00FF, 16'h0000, 16'h0000, 8'h00, 8'h00};
  localparam cst_flags_t FLAGS_RST = 8'hD0;

endpackage : cst_pkg

// *** design/cst_seq.sv ***
// Bus-cycle sequencer for subtract-double, trap, transfers, test and compare-with-zero.
`timescale 1ns/1ns
module cst_seq #(
  parameter logic [15:0] TRAP_VEC = cst_pkg::TRAP_VEC_DFLT
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic test_mode,
  input wire logic nmi_taken,
  input wire logic [7:0] bus_rdata,
  output cst_pkg::cst_bus_t bus,
  output cst_pkg::cst_regs_t regs,
  output cst_pkg::cst_flags_t flags,
  output logic illegal_op
);

  cst_pkg::cst_state_t state_q;
  logic [3:0] step_q;
  logic pfx_q;
  logic [7:0] op_q;
  logic [15:0] ea_q;
  logic [15:0] tmp_q;
  cst_pkg::cst_regs_t regs_q;
  cst_pkg::cst_flags_t flags_q;
  logic illegal_q;

  cst_pkg::cst_amode_t am;
  logic [3:0] k;
  logic [3:0] d0;
  logic [3:0] last;
  logic is_mem;
  logic is_dsub;
  logic is_trap;
  logic is_cmpz;
  logic in_exec;
  logic done;
  logic f_pfx;
  logic f_test;
  logic f_legal;
  logic [15:0] sub_res;
  logic sub_n;
  logic sub_z;
  logic sub_v;
  logic sub_c;
  logic [7:0] b8_val;
  logic b8_n;
  logic b8_z;
  cst_pkg::cst_flags_t tap_flags;

  function automatic cst_pkg::cst_amode_t amode_of(input logic [7:0] op);
    case (op)
      cst_pkg::OP_DSUB_IMM: amode_of = cst_pkg::AM_IMM;
      cst_pkg::OP_DSUB_DIR: amode_of = cst_pkg::AM_DIR;
      cst_pkg::OP_DSUB_EXT, cst_pkg::OP_CMPZ_EXT: amode_of = cst_pkg::AM_EXT;
      cst_pkg::OP_DSUB_IDX, cst_pkg::OP_CMPZ_IDX: amode_of = cst_pkg::AM_IDX;
      default: amode_of = cst_pkg::AM_INH;
    endcase
  endfunction : amode_of

  function automatic logic legal_op(input logic [7:0] op, input logic pfx);
    if (pfx)
    begin
      legal_op = (op == cst_pkg::OP_DSUB_IDX) || (op == cst_pkg::OP_CMPZ_IDX);
    end
    else
    begin
      legal_op = (amode_of(op) != cst_pkg::AM_INH) || (op == cst_pkg::OP_TRAP) || (op == cst_pkg::OP_A2B)
        || (op == cst_pkg::OP_B2A) || (op == cst_pkg::OP_TAP) || (op == cst_pkg::OP_RDFLAGS)
        || (op == cst_pkg::OP_CMPZ_A) || (op == cst_pkg::OP_CMPZ_B);
    end
  endfunction : legal_op

  assign am = amode_of(op_q);
  assign k = step_q - {3'h0, pfx_q};
  assign is_mem = (am != cst_pkg::AM_INH);
  assign is_dsub = is_mem && (op_q[1:0] == 2'h3);
  assign is_trap = (op_q == cst_pkg::OP_TRAP);
  assign is_cmpz = (op_q == cst_pkg::OP_CMPZ_A) || (op_q == cst_pkg::OP_CMPZ_B) || (is_mem && !is_dsub);
  assign in_exec = (state_q == cst_pkg::ST_EXEC);
  assign d0 = (am == cst_pkg::AM_IMM) ? cst_pkg::CYC_OPND :
              (am == cst_pkg::AM_DIR) ? cst_pkg::CYC_DIR_DATA : cst_pkg::CYC_EXT_DATA;
  assign last = is_trap ? cst_pkg::CYC_TRAP_LAST : (is_mem ? d0 + 4'h2 : cst_pkg::CYC_OPND);
  assign done = in_exec && (k == last);

  assign f_pfx = !pfx_q && (bus_rdata == cst_pkg::OP_PFX_Y);
  assign f_test = test_mode && !pfx_q && (bus_rdata == cst_pkg::OP_TEST);
  assign f_legal = legal_op(bus_rdata, pfx_q);

  cst_sub16 u_sub16 (
    .d_val({regs_q.a, regs_q.b}),
    .m_val(tmp_q),
    .res(sub_res),
    .neg(sub_n),
    .zero(sub_z),
    .ovf(sub_v),
    .borrow(sub_c)
  );

  always_comb
  begin
    b8_val = tmp_q[15:8];
    if (op_q == cst_pkg::OP_A2B || op_q == cst_pkg::OP_CMPZ_A)
    begin
      b8_val = regs_q.a;
    end
    else if (op_q == cst_pkg::OP_B2A || op_q == cst_pkg::OP_CMPZ_B)
    begin
      b8_val = regs_q.b;
    end
  end

  cst_flag8 u_flag8 (
    .val(b8_val),
    .tap_src(regs_q.a),
    .cur(flags_q),
    .neg(b8_n),
    .zero(b8_z),
    .tap_flags(tap_flags)
  );

  // Address, direction and write data of the current bus cycle.
  always_comb
  begin
    bus.addr = regs_q.pc;
    bus.wdata = 8'h00;
    bus.rd_nwr = 1'b1;
    if (in_exec && is_trap)
    begin
      if (k >= cst_pkg::CYC_PUSH0 && k <= cst_pkg::CYC_PUSH8)
      begin
        bus.addr = regs_q.sp;
        bus.rd_nwr = 1'b0;
        unique case (k)
          4'h3: bus.wdata = regs_q.pc[7:0];
          4'h4: bus.wdata = regs_q.pc[15:8];
          4'h5: bus.wdata = regs_q.iy[7:0];
          4'h6: bus.wdata = regs_q.iy[15:8];
          4'h7: bus.wdata = regs_q.ix[7:0];
          4'h8: bus.wdata = regs_q.ix[15:8];
          4'h9: bus.wdata = regs_q.a;
          4'hA: bus.wdata = regs_q.b;
          default: bus.wdata = flags_q;
        endcase
      end
      else if (k == cst_pkg::CYC_REREAD)
      begin
        bus.addr = regs_q.sp + 16'h0001;
      end
      else if (k == cst_pkg::CYC_VEC_HI)
      begin
        bus.addr = TRAP_VEC;
      end
      else if (k == cst_pkg::CYC_TRAP_LAST)
      begin
        bus.addr = TRAP_VEC + 16'h0001;
      end
    end
    else if (in_exec && is_mem)
    begin
      if (k < d0)
      begin
        if (am == cst_pkg::AM_IDX && k == 4'h3)
        begin
          bus.addr = cst_pkg::IDLE_ADDR;
        end
      end
      else if (k == d0)
      begin
        bus.addr = (am == cst_pkg::AM_IMM) ? regs_q.pc : ea_q;
      end
      else if (k == d0 + 4'h1)
      begin
        bus.addr = (am == cst_pkg::AM_IMM) ? regs_q.pc : (is_dsub ? ea_q + 16'h0001 : cst_pkg::IDLE_ADDR);
      end
      else
      begin
        bus.addr = cst_pkg::IDLE_ADDR;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= cst_pkg::ST_FETCH;
      step_q <= cst_pkg::CYC_FIRST;
      pfx_q <= 1'b0;
      op_q <= 8'h00;
    end
    else
    begin
      unique case (state_q)
        cst_pkg::ST_FETCH:
        begin
          if (f_pfx)
          begin
            pfx_q <= 1'b1;
            step_q <= cst_pkg::CYC_OPND;
          end
          else if (f_test)
          begin
            state_q <= cst_pkg::ST_TEST;
          end
          else if (f_legal)
          begin
            state_q <= cst_pkg::ST_EXEC;
            op_q <= bus_rdata;
            step_q <= step_q + 4'h1;
          end
          else
          begin
            pfx_q <= 1'b0;
            step_q <= cst_pkg::CYC_FIRST;
          end
        end
        cst_pkg::ST_EXEC:
        begin
          if (done)
          begin
            state_q <= cst_pkg::ST_FETCH;
            step_q <= cst_pkg::CYC_FIRST;
            pfx_q <= 1'b0;
          end
          else
          begin
            step_q <= step_q + 4'h1;
          end
        end
        cst_pkg::ST_TEST:
        begin
          state_q <= cst_pkg::ST_TEST;
        end
        default:
        begin
          state_q <= cst_pkg::ST_FETCH;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      illegal_q <= 1'b0;
    end
    else
    begin
      illegal_q <= (state_q == cst_pkg::ST_FETCH) && !f_pfx && !f_test && !f_legal;
    end
  end

  // Effective address and operand capture.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ea_q <= 16'h0000;
      tmp_q <= 16'h0000;
    end
    else if (in_exec)
    begin
      if (is_mem && k == cst_pkg::CYC_OPND)
      begin
        unique case (am)
          cst_pkg::AM_DIR: ea_q <= {8'h00, bus_rdata};
          cst_pkg::AM_EXT: ea_q[15:8] <= bus_rdata;
          cst_pkg::AM_IDX: ea_q <= (pfx_q ? regs_q.iy : regs_q.ix) + {8'h00, bus_rdata};
          default: ea_q <= ea_q;
        endcase
      end
      if (am == cst_pkg::AM_EXT && k == 4'h3)
      begin
        ea_q[7:0] <= bus_rdata;
      end
      if (is_mem && k == d0)
      begin
        tmp_q[15:8] <= bus_rdata;
      end
      if (is_dsub && k == d0 + 4'h1)
      begin
        tmp_q[7:0] <= bus_rdata;
      end
      if (is_trap && k == cst_pkg::CYC_VEC_HI)
      begin
        tmp_q[15:8] <= bus_rdata;
      end
    end
  end

  // Programmer-visible registers.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      regs_q <= cst_pkg::REGS_RST;
    end
    else
    begin
      if (state_q == cst_pkg::ST_FETCH || state_q == cst_pkg::ST_TEST)
      begin
        regs_q.pc <= regs_q.pc + 16'h0001;
      end
      if (in_exec && is_mem && (k == cst_pkg::CYC_OPND || (k == 4'h3 && (am == cst_pkg::AM_IMM
          || am == cst_pkg::AM_EXT))))
      begin
        regs_q.pc <= regs_q.pc + 16'h0001;
      end
      if (in_exec && is_trap && k >= cst_pkg::CYC_PUSH0 && k <= cst_pkg::CYC_PUSH8)
      begin
        regs_q.sp <= regs_q.sp - 16'h0001;
      end
      if (done && is_trap)
      begin
        regs_q.pc <= {tmp_q[15:8], bus_rdata};
      end
      if (done && is_dsub)
      begin
        {regs_q.a, regs_q.b} <= sub_res;
      end
      if (done && op_q == cst_pkg::OP_A2B)
      begin
        regs_q.b <= regs_q.a;
      end
      if (done && op_q == cst_pkg::OP_B2A)
      begin
        regs_q.a <= regs_q.b;
      end
      if (done && op_q == cst_pkg::OP_RDFLAGS)
      begin
        regs_q.a <= flags_q;
      end
    end
  end

  // Condition flags.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      flags_q <= cst_pkg::FLAGS_RST;
    end
    else
    begin
      if (done)
      begin
        if (is_dsub)
        begin
          flags_q.n <= sub_n;
          flags_q.z <= sub_z;
          flags_q.v <= sub_v;
          flags_q.c <= sub_c;
        end
        else if (op_q == cst_pkg::OP_A2B || op_q == cst_pkg::OP_B2A || is_cmpz)
        begin
          flags_q.n <= b8_n;
          flags_q.z <= b8_z;
          flags_q.v <= 1'b0;
          if (is_cmpz)
          begin
            flags_q.c <= 1'b0;
          end
        end
        else if (op_q == cst_pkg::OP_TAP)
        begin
          flags_q <= tap_flags;
        end
        else if (is_trap)
        begin
          flags_q.i <= 1'b1;
        end
      end
      if (nmi_taken)
      begin
        flags_q.x <= 1'b1;
      end
    end
  end

  assign regs = regs_q;
  assign flags = flags_q;
  assign illegal_op = illegal_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_op(logic [7:0] opc);
    state_q == cst_pkg::ST_FETCH && !pfx_q && bus_rdata == opc && !(test_mode && opc == cst_pkg::OP_TEST);
  endsequence
  sequence s_pushes;
    (!bus.rd_nwr)[*8] ##1 !bus.rd_nwr ##1 bus.rd_nwr;
  endsequence
  sequence s_vector;
    bus.addr == TRAP_VEC ##1 bus.addr == TRAP_VEC + 16'h0001 ##1 flags.i && state_q == cst_pkg::ST_FETCH;
  endsequence

  property p_trap_writes;
    s_op(cst_pkg::OP_TRAP) |-> ##2 s_pushes;
  endproperty
  a_trap_writes: assert property (p_trap_writes) else $error("trap write cycles wrong");

  property p_trap_sp;
    s_op(cst_pkg::OP_TRAP) |-> ##11 regs.sp == $past(regs.sp, 11) - 16'h0009;
  endproperty
  a_trap_sp: assert property (p_trap_sp) else $error("trap stack pointer not nine lower");

  property p_trap_vec;
    s_op(cst_pkg::OP_TRAP) |-> ##11 (bus.rd_nwr && bus.addr == regs.sp + 16'h0001) ##1 s_vector;
  endproperty
  a_trap_vec: assert property (p_trap_vec) else $error("trap reread or vector fetch wrong");

  property p_dsub_imm;
    s_op(cst_pkg::OP_DSUB_IMM) |-> ##3 bus.addr == cst_pkg::IDLE_ADDR ##1 state_q == cst_pkg::ST_FETCH;
  endproperty
  a_dsub_imm: assert property (p_dsub_imm) else $error("immediate subtract not four cycles");

  property p_dsub_res;
    done && is_dsub |=> {regs.a, regs.b} == $past({regs.a, regs.b}) - $past(tmp_q)
      && flags.c == ($past(tmp_q) > $past({regs.a, regs.b}));
  endproperty
  a_dsub_res: assert property (p_dsub_res) else $error("subtract result or borrow wrong");

  property p_x_rise;
    $rose(flags.x) |-> $past(nmi_taken);
  endproperty
  a_x_rise: assert property (p_x_rise) else $error("nonmaskable mask set without recognition");

  property p_test_run;
    state_q == cst_pkg::ST_TEST |=> state_q == cst_pkg::ST_TEST && regs.pc == $past(regs.pc) + 16'h0001;
  endproperty
  a_test_run: assert property (p_test_run) else $error("test mode counter stalled");

  property p_zero_illegal;
    state_q == cst_pkg::ST_FETCH && !pfx_q && bus_rdata == cst_pkg::OP_TEST && !test_mode |=> illegal_op;
  endproperty
  a_zero_illegal: assert property (p_zero_illegal) else $error("zero opcode accepted outside test mode");

  property p_rdflags;
    s_op(cst_pkg::OP_RDFLAGS) |-> ##2 regs.a == $past(flags);
  endproperty
  a_rdflags: assert property (p_rdflags) else $error("flags not copied into A");

  property p_cmpz_nowrite;
    in_exec && is_cmpz |-> bus.rd_nwr ##1 $stable({regs.a, regs.b});
  endproperty
  a_cmpz_nowrite: assert property (p_cmpz_nowrite) else $error("compare wrote memory or register");

endmodule : cst_seq

// *** design/cst_sub16.sv ***
// Sixteen-bit subtractor with its condition flag terms.
`timescale 1ns/1ns
module cst_sub16 (
  input wire logic [15:0] d_val,
  input wire logic [15:0] m_val,
  output logic [15:0] res,
  output logic neg,
  output logic zero,
  output logic ovf,
  output logic borrow
);

  assign res = d_val - m_val;
  assign neg = res[15];
  assign zero = (res == 16'h0000);
  assign ovf = (d_val[15] & ~m_val[15] & ~res[15]) | (~d_val[15] & m_val[15] & res[15]);
  assign borrow = (~d_val[15] & m_val[15]) | (m_val[15] & res[15]) | (res[15] & ~d_val[15]);

endmodule : cst_sub16
